//--- include/tcm_consts.vh
// constants for the channel 3/4 mode configuration block
// assumes a 32-bit apb bus with byte addresses
`ifndef TCM_CONSTS_VH
`define TCM_CONSTS_VH
`define TCM_ADDR_W 8
`define TCM_OFS_MODE 8'h1C
`define TCM_OFS_ENABLE 8'h20
`define TCM_OFS_CAP3 8'h3C
`define TCM_OFS_CAP4 8'h40
`define TCM_MODE_RESET 16'h0000
`define TCM_ENABLE_RESET 16'h0000
`define TCM_ENABLE_MASK 16'h3300
`define TCM_CH3_SEL_LSB 0
`define TCM_CH3_FAST 2
`define TCM_CH3_PRELOAD 3
`define TCM_CH3_MODE_LSB 4
`define TCM_CH3_CLEAR 7
`define TCM_CH3_PSC_LSB 2
`define TCM_CH3_FILT_LSB 4
`define TCM_CH4_SEL_LSB 8
`define TCM_CH4_FAST 10
`define TCM_CH4_PRELOAD 11
`define TCM_CH4_MODE_LSB 12
`define TCM_CH4_CLEAR 15
`define TCM_CH4_PSC_LSB 10
`define TCM_CH4_FILT_LSB 12
`define TCM_CH3_EN_BIT 8
`define TCM_CH4_EN_BIT 12
`define TCM_SEL_OUTPUT 2'h0
`define TCM_SEL_OWN_PIN 2'h1
`define TCM_SEL_NEIGHBOUR 2'h2
`define TCM_SEL_TRIGGER 2'h3
`endif

//--- design/tcm_capture_path.v
// one input-capture path: source select, filter, prescaler, capture
// assumes pins and trigger are synchronous to clk, rst_n already synced
`timescale 1ns/1ps
`include "tcm_consts.vh"
module tcm_capture_path #(
  parameter CNT_W = 16
) (
  clk,
  rst_n,
  pin_own,
  pin_neighbour,
  internal_trigger_source,
  direction_select,
  input_filter,
  capture_prescaler,
  enable_bit,
  counter_value,
  capture_value,
  capture_event
);
  input wire clk;
  input wire rst_n;
  input wire pin_own;
  input wire pin_neighbour;
  input wire internal_trigger_source;
  input wire [1:0] direction_select;
  input wire [3:0] input_filter;
  input wire [1:0] capture_prescaler;
  input wire enable_bit;
  input wire [CNT_W-1:0] counter_value;
  output reg [CNT_W-1:0] capture_value;
  output reg capture_event;

  reg [4:0] div_m1;
  reg [2:0] n_m1;
  reg src;
  reg [4:0] div_cnt;
  reg [2:0] eq_cnt;
  reg filt_level;
  reg filt_prev;
  reg [2:0] psc_cnt;
  wire is_input;
  wire tick;
  wire edge_seen;
  wire [2:0] psc_top;

  // filter table: sampling divider minus one, sample count minus one
  always @* begin
    case (input_filter)
      4'h1: {div_m1, n_m1} = {5'h00, 3'h1};
      4'h2: {div_m1, n_m1} = {5'h00, 3'h3};
      4'h3: {div_m1, n_m1} = {5'h00, 3'h7};
      4'h4: {div_m1, n_m1} = {5'h01, 3'h5};
      4'h5: {div_m1, n_m1} = {5'h01, 3'h7};
      4'h6: {div_m1, n_m1} = {5'h03, 3'h5};
      4'h7: {div_m1, n_m1} = {5'h03, 3'h7};
      4'h8: {div_m1, n_m1} = {5'h07, 3'h5};
      4'h9: {div_m1, n_m1} = {5'h07, 3'h7};
      4'hA: {div_m1, n_m1} = {5'h0F, 3'h4};
      4'hB: {div_m1, n_m1} = {5'h0F, 3'h5};
      4'hC: {div_m1, n_m1} = {5'h0F, 3'h7};
      4'hD: {div_m1, n_m1} = {5'h1F, 3'h4};
      4'hE: {div_m1, n_m1} = {5'h1F, 3'h5};
      4'hF: {div_m1, n_m1} = {5'h1F, 3'h7};
      default: {div_m1, n_m1} = {5'h00, 3'h0};
    endcase
  end

  always @* begin
    case (direction_select)
      `TCM_SEL_OWN_PIN: src = pin_own;
      `TCM_SEL_NEIGHBOUR: src = pin_neighbour;
      `TCM_SEL_TRIGGER: src = internal_trigger_source;
      default: src = 1'b0;
    endcase
  end

  assign is_input = (direction_select != `TCM_SEL_OUTPUT);
  assign tick = (div_cnt == div_m1);
  assign edge_seen = filt_level & ~filt_prev;
  // code 11 shifts out of three bits and wraps to seven on purpose
  assign psc_top = (3'h1 << capture_prescaler) - 3'h1;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 5'h00;
      eq_cnt <= 3'h0;
      filt_level <= 1'b0;
      filt_prev <= 1'b0;
      psc_cnt <= 3'h0;
      capture_value <= {CNT_W{1'b0}};
      capture_event <= 1'b0;
    end else begin
      div_cnt <= tick ? 5'h00 : div_cnt + 5'h01;
      filt_prev <= filt_level;
      capture_event <= 1'b0;
      if (input_filter == 4'h0) begin
        filt_level <= src;
        eq_cnt <= 3'h0;
      end else if (tick) begin
        // a level is taken only after n equal samples in a row
        if (src == filt_level)
          eq_cnt <= 3'h0;
        else if (eq_cnt == n_m1) begin
          filt_level <= src;
          eq_cnt <= 3'h0;
        end else
          eq_cnt <= eq_cnt + 3'h1;
      end
      if (!is_input || !enable_bit)
        psc_cnt <= 3'h0;
      else if (edge_seen) begin
        if (psc_cnt >= psc_top) begin
          psc_cnt <= 3'h0;
          capture_value <= counter_value;
          capture_event <= 1'b1;
        end else
          psc_cnt <= psc_cnt + 3'h1;
      end
    end
  end
endmodule

//--- design/tcm_top.v
// channel 3/4 capture/compare mode configuration with apb registers
// assumes an external counter, compare logic and trigger sources on clk
//
// Operation
// - channel 4 output layout: bit10 fast, bit11 preload, 14:12 mode, 15 clear
// - channel 4 direction 9:8: output, pin four, pin three, internal trigger
// - channel 3 direction 1:0: output, pin three, pin four, internal trigger
// - direction field writable only while that channel's enable bit is zero
// - channel 3 prescaler 3:2 captures once per 1, 2, 4 or 8 events
// - input layout: ch3 filter 7:4, ch4 prescaler 11:10, ch4 filter 15:12
// - filter code 0000 bypasses; others pick divider and equal-sample count
// - clear enable forces output reference low while external trigger high
// - fast enable shortens trigger-to-compare-output delay
// - input channel captures counter only while its enable bit is set
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "tcm_consts.vh"
module tcm_top #(
  parameter CNT_W = 16
) (
  clk,
  rst_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  timer_input_pin_three,
  timer_input_pin_four,
  internal_trigger_source,
  filtered_external_trigger,
  trigger_event,
  counter_value,
  ch3_compare_ref_raw,
  ch4_compare_ref_raw,
  ch3_output_reference,
  ch4_output_reference,
  ch3_compare_act,
  ch4_compare_act,
  ch3_preload_enable,
  ch4_preload_enable,
  ch3_compare_mode,
  ch4_compare_mode,
  ch3_output_enable,
  ch4_output_enable,
  ch3_capture_event,
  ch4_capture_event
);
  input wire clk;
  input wire rst_n;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [`TCM_ADDR_W-1:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire timer_input_pin_three;
  input wire timer_input_pin_four;
  input wire internal_trigger_source;
  input wire filtered_external_trigger;
  input wire trigger_event;
  input wire [CNT_W-1:0] counter_value;
  input wire ch3_compare_ref_raw;
  input wire ch4_compare_ref_raw;
  output reg ch3_output_reference;
  output reg ch4_output_reference;
  output reg ch3_compare_act;
  output reg ch4_compare_act;
  output wire ch3_preload_enable;
  output wire ch4_preload_enable;
  output wire [2:0] ch3_compare_mode;
  output wire [2:0] ch4_compare_mode;
  output wire ch3_output_enable;
  output wire ch4_output_enable;
  output wire ch3_capture_event;
  output wire ch4_capture_event;

  reg rst_meta;
  reg rst_sync_n;
  reg [15:0] mode_reg;
  reg [15:0] enable_reg;
  reg trigger_d;
  reg [15:0] next_mode;
  reg [31:0] next_rdata;
  wire [CNT_W-1:0] cap_val [0:1];
  wire [1:0] cap_evt;
  wire access;
  wire wr;
  wire hit;
  wire [1:0] ch3_direction_select;
  wire [1:0] ch4_direction_select;
  wire ch3_enable_bit;
  wire ch4_enable_bit;
  wire ch3_fast_enable;
  wire ch4_fast_enable;
  wire ch3_ref_clear_enable;
  wire ch4_ref_clear_enable;
  wire [1:0] ch3_capture_prescaler;
  wire [1:0] ch4_capture_prescaler;
  wire [3:0] ch3_input_filter;
  wire [3:0] ch4_input_filter;

  // async assert, clocked release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // the same sixteen bits give both layouts; direction picks the meaning
  assign ch3_direction_select = mode_reg[`TCM_CH3_SEL_LSB+1:`TCM_CH3_SEL_LSB];
  assign ch4_direction_select = mode_reg[`TCM_CH4_SEL_LSB+1:`TCM_CH4_SEL_LSB];
  assign ch3_fast_enable = mode_reg[`TCM_CH3_FAST];
  assign ch3_preload_enable = mode_reg[`TCM_CH3_PRELOAD];
  assign ch3_compare_mode = mode_reg[`TCM_CH3_MODE_LSB+2:`TCM_CH3_MODE_LSB];
  assign ch3_ref_clear_enable = mode_reg[`TCM_CH3_CLEAR];
  assign ch4_fast_enable = mode_reg[`TCM_CH4_FAST];
  assign ch4_preload_enable = mode_reg[`TCM_CH4_PRELOAD];
  assign ch4_compare_mode = mode_reg[`TCM_CH4_MODE_LSB+2:`TCM_CH4_MODE_LSB];
  assign ch4_ref_clear_enable = mode_reg[`TCM_CH4_CLEAR];
  assign ch3_capture_prescaler = mode_reg[`TCM_CH3_PSC_LSB+1:`TCM_CH3_PSC_LSB];
  assign ch3_input_filter = mode_reg[`TCM_CH3_FILT_LSB+3:`TCM_CH3_FILT_LSB];
  assign ch4_capture_prescaler = mode_reg[`TCM_CH4_PSC_LSB+1:`TCM_CH4_PSC_LSB];
  assign ch4_input_filter = mode_reg[`TCM_CH4_FILT_LSB+3:`TCM_CH4_FILT_LSB];
  assign ch3_enable_bit = enable_reg[`TCM_CH3_EN_BIT];
  assign ch4_enable_bit = enable_reg[`TCM_CH4_EN_BIT];
  assign ch3_output_enable = ch3_enable_bit &
                             (ch3_direction_select == `TCM_SEL_OUTPUT);
  assign ch4_output_enable = ch4_enable_bit &
                             (ch4_direction_select == `TCM_SEL_OUTPUT);

  // apb slave: zero wait states, error on unmapped address
  assign access = psel & penable;
  assign pready = 1'b1;
  assign hit = (paddr == `TCM_OFS_MODE) | (paddr == `TCM_OFS_ENABLE) |
               (paddr == `TCM_OFS_CAP3) | (paddr == `TCM_OFS_CAP4);
  assign pslverr = access & ~hit;
  assign wr = access & pwrite;

  always @* begin
    next_rdata = 32'h00000000;
    case (paddr)
      `TCM_OFS_MODE: next_rdata[15:0] = mode_reg;
      `TCM_OFS_ENABLE: next_rdata[15:0] = enable_reg;
      `TCM_OFS_CAP3: next_rdata[CNT_W-1:0] = cap_val[0];
      `TCM_OFS_CAP4: next_rdata[CNT_W-1:0] = cap_val[1];
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read data taken in the setup cycle so it stands through the access
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      prdata <= next_rdata;
    end
  end

  // direction bits keep their value while the channel is running
  always @* begin
    next_mode = pwdata[15:0];
    if (ch3_enable_bit)
      next_mode[`TCM_CH3_SEL_LSB+1:`TCM_CH3_SEL_LSB] =
        ch3_direction_select;
    if (ch4_enable_bit)
      next_mode[`TCM_CH4_SEL_LSB+1:`TCM_CH4_SEL_LSB] =
        ch4_direction_select;
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_reg <= `TCM_MODE_RESET;
      enable_reg <= `TCM_ENABLE_RESET;
    end else if (wr) begin
      if (paddr == `TCM_OFS_MODE)
        mode_reg <= next_mode;
      if (paddr == `TCM_OFS_ENABLE)
        enable_reg <= pwdata[15:0] & `TCM_ENABLE_MASK;
    end
  end

  // output reference and trigger response, both channels
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trigger_d <= 1'b0;
      ch3_output_reference <= 1'b0;
      ch4_output_reference <= 1'b0;
      ch3_compare_act <= 1'b0;
      ch4_compare_act <= 1'b0;
    end else begin
      trigger_d <= trigger_event;
      ch3_output_reference <= ch3_compare_ref_raw &
        ~(ch3_ref_clear_enable & filtered_external_trigger);
      ch4_output_reference <= ch4_compare_ref_raw &
        ~(ch4_ref_clear_enable & filtered_external_trigger);
      // fast path skips one register stage of trigger latency
      ch3_compare_act <= ch3_fast_enable ? trigger_event : trigger_d;
      ch4_compare_act <= ch4_fast_enable ? trigger_event : trigger_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      // channel 3 owns pin three, channel 4 owns pin four
      tcm_capture_path #(
        .CNT_W(CNT_W)
      ) u_path (
        .clk(clk),
        .rst_n(rst_sync_n),
        .pin_own(gi == 0 ? timer_input_pin_three
                         : timer_input_pin_four),
        .pin_neighbour(gi == 0 ? timer_input_pin_four
                               : timer_input_pin_three),
        .internal_trigger_source(internal_trigger_source),
        .direction_select(gi == 0 ? ch3_direction_select
                                  : ch4_direction_select),
        .input_filter(gi == 0 ? ch3_input_filter : ch4_input_filter),
        .capture_prescaler(gi == 0 ? ch3_capture_prescaler
                                   : ch4_capture_prescaler),
        .enable_bit(gi == 0 ? ch3_enable_bit : ch4_enable_bit),
        .counter_value(counter_value),
        .capture_value(cap_val[gi]),
        .capture_event(cap_evt[gi])
      );
    end
  endgenerate

  assign ch3_capture_event = cap_evt[0];
  assign ch4_capture_event = cap_evt[1];
endmodule

//--- dv/tcm_top_chk.sv
// assertions on the ports of the channel 3/4 mode block
// assumes one clock domain and rst_n active low at the top ports
`timescale 1ns/1ps
`include "tcm_consts.vh"
module tcm_chk (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`TCM_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire filtered_external_trigger,
  input wire trigger_event,
  input wire ch3_compare_ref_raw,
  input wire ch4_compare_ref_raw,
  input wire ch3_output_reference,
  input wire ch4_output_reference,
  input wire ch3_compare_act,
  input wire ch4_compare_act,
  input wire ch4_preload_enable,
  input wire [2:0] ch4_compare_mode,
  input wire ch3_output_enable,
  input wire ch4_output_enable,
  input wire ch3_capture_event
);
  wire wr_mode;
  assign wr_mode = psel && penable && pwrite && paddr == `TCM_OFS_MODE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ch4_out_layout: assert property (wr_mode |=>
    ch4_compare_mode == $past(pwdata[14:12]) &&
    ch4_preload_enable == $past(pwdata[11]))
    else $error("ch4 output fields do not follow the mode write");
  a_ch3_sel_lock: assert property (wr_mode && ch3_output_enable |=>
    ch3_output_enable) else $error("ch3 direction changed while enabled");
  a_ch4_sel_lock: assert property (wr_mode && ch4_output_enable |=>
    ch4_output_enable) else $error("ch4 direction changed while enabled");
  a_ref_low_raw: assert property (!ch4_compare_ref_raw |=>
    !ch4_output_reference) else $error("ch4 reference high without raw");
  a_ref_pass_idle: assert property (
    ch3_compare_ref_raw && !filtered_external_trigger |=> ch3_output_reference)
    else $error("ch3 reference cleared with trigger low");
  a_act_bounded: assert property (trigger_event |-> ##[1:2]
    ch4_compare_act) else $error("ch4 compare action missing");
  a_act_cause: assert property ($rose(ch3_compare_act) |->
    $past(trigger_event) || $past(trigger_event, 2))
    else $error("ch3 compare action without trigger");
  a_cap_input_only: assert property (ch3_capture_event |->
    !ch3_output_enable) else $error("ch3 captured while in output mode");
endmodule

//--- dv/timer_ch34_mode_config_bench.sv
// self-checking bench for the channel 3/4 mode configuration block
// assumes tcm_top with a zero-wait apb slave and a 250 MHz clock
`timescale 1ns/1ps
`include "tcm_consts.vh"
module timer_ch34_mode_config_bench;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [`TCM_ADDR_W-1:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, ext = 0, trig = 0, raw3 = 0, raw4 = 0;
  logic [2:0] src = 0;
  logic [15:0] cnt = 0;
  logic oref3, oref4, act3, act4, pre3, pre4, oe3, oe4, cap3, cap4;
  logic [2:0] mode3, mode4;
  int n_errors = 0, n_compared = 0, ncap3 = 0, ncap4 = 0;
  tcm_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_input_pin_three(src[0]),
    .timer_input_pin_four(src[1]), .internal_trigger_source(src[2]),
    .filtered_external_trigger(ext), .trigger_event(trig),
    .counter_value(cnt), .ch3_compare_ref_raw(raw3),
    .ch4_compare_ref_raw(raw4), .ch3_output_reference(oref3),
    .ch4_output_reference(oref4), .ch3_compare_act(act3),
    .ch4_compare_act(act4), .ch3_preload_enable(pre3),
    .ch4_preload_enable(pre4), .ch3_compare_mode(mode3),
    .ch4_compare_mode(mode4), .ch3_output_enable(oe3),
    .ch4_output_enable(oe4), .ch3_capture_event(cap3),
    .ch4_capture_event(cap4));
  initial begin
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cap3 === 1'b1) ncap3++;
    if (cap4 === 1'b1) ncap4++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [`TCM_ADDR_W-1:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) chk(0, 1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic t_reset;
    apb(0, `TCM_OFS_MODE, 0);
    chk(rd, 0);
    apb(0, `TCM_OFS_ENABLE, 0);
    chk(rd, 0);
    apb(0, 8'h44, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("reset test done");
  endtask
  task automatic t_capture(input int ch, input logic [1:0] sel, psc,
    input logic [3:0] filt, input int w, input logic en, input int exp);
    logic [15:0] m;
    int idx;
    m = 16'({filt, psc, sel}) << (8 * ch);
    // pin three and pin four swap roles between the two channels
    idx = sel == 3 ? 2 : (int'(sel) - 1) ^ ch;
    apb(1, `TCM_OFS_ENABLE, 0);
    apb(1, `TCM_OFS_MODE, m);
    apb(0, `TCM_OFS_MODE, 0);
    chk(rd, m);
    apb(1, `TCM_OFS_ENABLE, 32'(en) << (8 + 4 * ch));
    cnt <= cnt + 16'h0101;
    ncap3 = 0;
    ncap4 = 0;
    repeat (8) begin
      @(posedge clk);
      src[idx] <= 1;
      repeat (w) @(posedge clk);
      src[idx] <= 0;
      repeat (12) @(posedge clk);
    end
    chk(ch ? ncap4 : ncap3, exp);
    if (exp > 0) begin
      apb(0, ch ? `TCM_OFS_CAP4 : `TCM_OFS_CAP3, 0);
      chk(rd, cnt);
    end
    $display("capture test done");
  endtask
  task automatic t_lock;
    apb(1, `TCM_OFS_ENABLE, 0);
    apb(1, `TCM_OFS_MODE, 0);
    apb(1, `TCM_OFS_ENABLE, 32'h1100);
    apb(1, `TCM_OFS_MODE, 32'hB6FF);
    apb(0, `TCM_OFS_MODE, 0);
    chk(rd, 32'hB4FC);
    chk({oe3, oe4, pre3, pre4, mode3, mode4}, 10'b1110111011);
    $display("lock test done");
  endtask
  task automatic t_compare;
    int d3, d4;
    apb(1, `TCM_OFS_MODE, 32'hB400);
    raw3 <= 1;
    raw4 <= 1;
    ext <= 1;
    repeat (3) @(posedge clk);
    chk({oref3, oref4}, 2'b10);
    ext <= 0;
    repeat (3) @(posedge clk);
    chk({oref3, oref4}, 2'b11);
    d3 = 0;
    d4 = 0;
    trig <= 1;
    @(posedge clk);
    trig <= 0;
    for (int i = 1; i < 6; i++) begin
      @(negedge clk);
      if (d3 == 0 && act3 === 1'b1) d3 = i;
      if (d4 == 0 && act4 === 1'b1) d4 = i;
    end
    chk(d4 != 0, 1);
    chk(d3, d4 + 1);
    $display("compare test done");
  endtask
  task automatic test_done;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    t_reset;
    for (int p = 0; p < 4; p++) begin
      t_capture(0, 2'(p % 3 + 1), 2'(p), 0, 1, 1, 8 >> p);
      t_capture(1, 2'(p % 3 + 1), 2'(p), 0, 1, 1, 8 >> p);
    end
    t_capture(0, 1, 0, 4'h1, 1, 1, 0);
    t_capture(0, 1, 0, 4'h1, 4, 1, 8);
    t_capture(1, 1, 0, 0, 1, 0, 0);
    t_lock;
    t_compare;
    test_done;
  end
endmodule
bind tcm_top tcm_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .filtered_external_trigger(filtered_external_trigger),
  .trigger_event(trigger_event), .ch3_compare_ref_raw(ch3_compare_ref_raw),
  .ch4_compare_ref_raw(ch4_compare_ref_raw),
  .ch3_output_reference(ch3_output_reference),
  .ch4_output_reference(ch4_output_reference),
  .ch3_compare_act(ch3_compare_act), .ch4_compare_act(ch4_compare_act),
  .ch4_preload_enable(ch4_preload_enable),
  .ch4_compare_mode(ch4_compare_mode),
  .ch3_output_enable(ch3_output_enable),
  .ch4_output_enable(ch4_output_enable),
  .ch3_capture_event(ch3_capture_event));
